// >>> verilog/ptc_pkg.sv
// constants for the pwm timer control block: register map, fields, encodings
// assumes a byte-wide register port addressed by the printed offsets
// How it works
// - channel b force strobe ignored while channel b pwm enable is set
// - channel b force applies programmed compare action, no interrupt, same-cycle mode bits used
// - channel b force strobe bit always reads zero
// - channel a pwm enable puts channel a into pwm from its compare register
// - channel b pwm enable puts channel b into pwm from its compare register
// - channel d pwm enable puts channel d into pwm from its compare register
// - pwm invert bit inverts both dead-time generator outputs
// - prescaler reset strobe clears prescaler only, self-clears, reads zero
// - dead-time prescaler divides timer clock by 1, 2, 4 or 8
// - clock select 0 stops timer, 1..15 give undivided up to divide by 16384
// - control d bits 7:6 mirror channel a compare-mode bits
// - any channel d compare-mode bit set overrides the port pin
// - complementary d output connects only in pwm with mode 01
// - channel d mode meaning depends on pwm enable and low wave-gen bit
// - non-pwm d modes: port, toggle, clear, set on match; true pin only
// - fast pwm: 01/10 clear on match set at zero; 11 opposite
// - correct pwm: 01/10 clear on up match set on down; 11 reverse
// - channel d force acts only in non-pwm, like a match, reads zero
// - wave-gen bits select fast, correct, single-slope six, dual-slope six pwm
// - top from channel c; compare update immediate, at top, or at bottom
package ptc_pkg;
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [7:0] OFS_WAVE_GEN = 8'h26;
    localparam logic [7:0] OFS_OUT_CTRL_D = 8'h27;
    localparam logic [7:0] OFS_CLK_CTRL = 8'h2F;
    localparam logic [7:0] OFS_OUT_CTRL_AB = 8'h30;
    localparam logic [7:0] RESET_VAL = 8'h00;
    // channel a/b control fields
    localparam int AB_MODE_A = 6;
    localparam int AB_MODE_B = 4;
    localparam int AB_FORCE_B = 2;
    localparam int AB_PWM_A = 1;
    localparam int AB_PWM_B = 0;
    // channel d control fields
    localparam int D_SHADOW_A = 6;
    localparam int D_SHADOW_B = 4;
    localparam int D_MODE_D = 2;
    localparam int D_FORCE_D = 1;
    localparam int D_PWM_D = 0;
    // clock control fields
    localparam int CK_INVERT = 7;
    localparam int CK_PSR = 6;
    localparam int CK_DT_DIV = 4;
    localparam int CK_SEL = 0;
    localparam int PRESC_W = 14;
    localparam int DT_W = 3;
    localparam logic [1:0] MODE_PORT = 2'h0;
    localparam logic [1:0] MODE_TOGGLE = 2'h1;
    localparam logic [1:0] MODE_CLEAR = 2'h2;
    localparam logic [1:0] MODE_SET = 2'h3;
    localparam logic [3:0] SEL_STOP = 4'h0;
    typedef enum logic [1:0] {PTC_UPD_IMMEDIATE, PTC_UPD_TOP, PTC_UPD_BOTTOM} ptc_update_e;
    typedef enum logic [2:0] {PTC_NORMAL, PTC_FAST, PTC_CORRECT, PTC_SIX_SINGLE, PTC_SIX_DUAL} ptc_wave_e;
endpackage

// >>> verilog/ptc_timer_ctrl.sv
// pwm timer control: prescalers, dead-time prescaler, inversion, channel b/d output logic
// assumes counter core, compare matches and dead-time generator outside, all on sys_clk_in
`timescale 1ns/100ps
module ptc_timer_ctrl #(
    parameter int CNT_W = 10
) (
    input wire logic sys_clk_in, // 40 MHz system clock
    input wire logic reset_in, // async reset, active high
    input wire logic [ptc_pkg::ADDR_W-1:0] addr_in, // register address
    input wire logic [ptc_pkg::DATA_W-1:0] wdata_in, // write data
    input wire logic wr_in, // write strobe
    input wire logic rd_in, // read strobe
    output logic [ptc_pkg::DATA_W-1:0] rdata_out, // read data, cycle after read
    input wire logic async_mode_in, // 1: count fast peripheral clock ticks
    input wire logic fast_clk_tick_in, // one-cycle tick of fast peripheral clock
    input wire logic [CNT_W-1:0] counter_value_in, // counter core value
    input wire logic counting_down_in, // counter direction in dual slope
    input wire logic match_b_in, // channel b compare match pulse
    input wire logic match_d_in, // channel d compare match pulse
    input wire logic dt_true_in, // dead-time generator true output
    input wire logic dt_comp_in, // dead-time generator complementary output
    output logic timer_tick_out, // prescaled timer count enable
    output logic dt_tick_out, // dead-time prescaler count enable
    output logic dt_true_out, // true output after inversion
    output logic dt_comp_out, // complementary output after inversion
    output logic pwm_a_out, // channel a in pwm operation
    output logic pwm_b_out, // channel b in pwm operation
    output logic pwm_d_out, // channel d in pwm operation
    output logic [1:0] mode_a_out, // channel a compare-mode bits
    output logic [2:0] wave_mode_out, // counter operating mode
    output logic [1:0] update_at_out, // compare register update point
    output logic wave_out_b_out, // channel b waveform
    output logic wave_out_d_out, // channel d waveform
    output logic compare_pin_d_out, // channel d true pin level
    output logic compare_pin_d_oe_out, // channel d true pin override
    output logic compare_pin_d_n_out, // channel d complementary pin level
    output logic compare_pin_d_n_oe_out // channel d complementary pin connect
);
    initial begin
        if (CNT_W < 2 || CNT_W > 16) begin
            $error("CNT_W out of range");
        end
    end

    typedef struct packed {
        logic [1:0] mode_a;
        logic [1:0] mode_b;
        logic pwm_a;
        logic pwm_b;
        logic [1:0] mode_d;
        logic pwm_d;
        logic invert;
        logic [1:0] dt_div;
        logic [3:0] clk_sel;
        logic [1:0] wave_gen;
        logic [ptc_pkg::PRESC_W-1:0] presc;
        logic [ptc_pkg::DT_W-1:0] dt_cnt;
        logic tick;
        logic dt_tick;
        logic dt_true;
        logic dt_comp;
        logic wave_b;
        logic wave_d;
        logic [ptc_pkg::DATA_W-1:0] rdata;
    } ptc_state_s;

    ptc_state_s st_q;
    ptc_state_s st_d;

    // next waveform level for one channel from its mode, pwm setting and events
    function automatic logic wave_next(input logic [1:0] mode, input logic pwm, input logic slope_dual,
                                       input logic cur, input logic match, input logic force_in,
                                       input logic at_zero, input logic down);
        logic v;
        v = cur;
        if (!pwm) begin
            if (match || force_in) begin
                case (mode)
                    ptc_pkg::MODE_TOGGLE: v = ~cur;
                    ptc_pkg::MODE_CLEAR: v = 1'b0;
                    ptc_pkg::MODE_SET: v = 1'b1;
                    default: v = cur;
                endcase
            end
        end else if (mode != ptc_pkg::MODE_PORT) begin
            if (!slope_dual) begin
                // match wins when match and zero coincide, e.g. compare 0
                if (at_zero) begin
                    v = (mode != ptc_pkg::MODE_SET);
                end
                if (match) begin
                    v = (mode == ptc_pkg::MODE_SET);
                end
            end else if (match) begin
                v = (mode == ptc_pkg::MODE_SET) ^ down;
            end
        end
        return v;
    endfunction

    // prescaler mask: a tick passes when the low sel-1 bits are all ones
    function automatic logic [ptc_pkg::PRESC_W-1:0] presc_mask(input logic [3:0] sel);
        logic [ptc_pkg::PRESC_W:0] m;
        m = '0;
        if (sel > 4'h1) begin
            m = (15'(1) << (sel - 4'h1)) - 15'(1);
        end
        return m[ptc_pkg::PRESC_W-1:0];
    endfunction

    logic wr_ab;
    logic wr_d;
    logic wr_ck;
    logic wr_wg;
    logic src_tick;
    logic force_b;
    logic force_d;
    logic at_zero;
    logic [1:0] mode_b_now;
    logic [1:0] mode_d_now;
    logic [ptc_pkg::PRESC_W-1:0] pmask;
    logic [ptc_pkg::DT_W-1:0] dmask;

    always_comb begin
        wr_ab = wr_in && addr_in == ptc_pkg::OFS_OUT_CTRL_AB;
        wr_d = wr_in && addr_in == ptc_pkg::OFS_OUT_CTRL_D;
        wr_ck = wr_in && addr_in == ptc_pkg::OFS_CLK_CTRL;
        wr_wg = wr_in && addr_in == ptc_pkg::OFS_WAVE_GEN;
        src_tick = async_mode_in ? fast_clk_tick_in : 1'b1;
        at_zero = counter_value_in == '0;
        // same-cycle mode writes are used by the force strobes
        mode_b_now = wr_ab ? wdata_in[ptc_pkg::AB_MODE_B +: 2] : st_q.mode_b;
        mode_d_now = wr_d ? wdata_in[ptc_pkg::D_MODE_D +: 2] : st_q.mode_d;
        force_b = wr_ab && wdata_in[ptc_pkg::AB_FORCE_B] && !st_q.pwm_b;
        force_d = wr_d && wdata_in[ptc_pkg::D_FORCE_D] && !st_q.pwm_d;
        pmask = presc_mask(st_q.clk_sel);
        // dead-time counter is three bits wide, so divide by 8 is the largest mask
        dmask = 3'((4'h1 << st_q.dt_div) - 4'h1);
        st_d = st_q;
        if (wr_ab) begin
            st_d.mode_a = wdata_in[ptc_pkg::AB_MODE_A +: 2];
            st_d.mode_b = wdata_in[ptc_pkg::AB_MODE_B +: 2];
            st_d.pwm_a = wdata_in[ptc_pkg::AB_PWM_A];
            st_d.pwm_b = wdata_in[ptc_pkg::AB_PWM_B];
        end
        if (wr_d) begin
            st_d.mode_a = wdata_in[ptc_pkg::D_SHADOW_A +: 2];
            st_d.mode_b = wdata_in[ptc_pkg::D_SHADOW_B +: 2];
            st_d.mode_d = wdata_in[ptc_pkg::D_MODE_D +: 2];
            st_d.pwm_d = wdata_in[ptc_pkg::D_PWM_D];
        end
        if (wr_ck) begin
            st_d.invert = wdata_in[ptc_pkg::CK_INVERT];
            st_d.dt_div = wdata_in[ptc_pkg::CK_DT_DIV +: 2];
            st_d.clk_sel = wdata_in[ptc_pkg::CK_SEL +: 4];
        end
        if (wr_wg) begin
            st_d.wave_gen = wdata_in[1:0];
        end
        // prescaler: the reset strobe is never stored, so it clears itself
        st_d.tick = 1'b0;
        if (wr_ck && wdata_in[ptc_pkg::CK_PSR]) begin
            st_d.presc = '0;
        end else if (st_q.clk_sel != ptc_pkg::SEL_STOP && src_tick) begin
            st_d.presc = st_q.presc + 1'b1;
            st_d.tick = (st_q.presc & pmask) == pmask;
        end
        st_d.dt_tick = 1'b0;
        if (st_q.tick) begin
            st_d.dt_cnt = st_q.dt_cnt + 1'b1;
            st_d.dt_tick = (st_q.dt_cnt & dmask) == dmask;
        end
        st_d.dt_true = dt_true_in ^ st_q.invert;
        st_d.dt_comp = dt_comp_in ^ st_q.invert;
        st_d.wave_b = wave_next(mode_b_now, st_q.pwm_b, st_q.wave_gen[0], st_q.wave_b, match_b_in, force_b,
                                at_zero, counting_down_in);
        st_d.wave_d = wave_next(mode_d_now, st_q.pwm_d, st_q.wave_gen[0], st_q.wave_d, match_d_in, force_d,
                                at_zero, counting_down_in);
        st_d.rdata = '0;
        if (rd_in) begin
            case (addr_in)
                ptc_pkg::OFS_OUT_CTRL_AB: st_d.rdata = {st_q.mode_a, st_q.mode_b, 2'h0,
                                                       st_q.pwm_a, st_q.pwm_b};
                ptc_pkg::OFS_OUT_CTRL_D: st_d.rdata = {st_q.mode_a, st_q.mode_b, st_q.mode_d,
                                                      1'b0, st_q.pwm_d};
                ptc_pkg::OFS_CLK_CTRL: st_d.rdata = {st_q.invert, 1'b0, st_q.dt_div, st_q.clk_sel};
                ptc_pkg::OFS_WAVE_GEN: st_d.rdata = {6'h00, st_q.wave_gen};
                default: st_d.rdata = '0;
            endcase
        end
    end

    always_ff @(posedge sys_clk_in or posedge reset_in) begin
        if (reset_in) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    logic any_pwm;
    always_comb begin
        any_pwm = st_q.pwm_a || st_q.pwm_b || st_q.pwm_d;
        case ({any_pwm, st_q.wave_gen})
            3'h4: wave_mode_out = 3'(ptc_pkg::PTC_FAST);
            3'h5: wave_mode_out = 3'(ptc_pkg::PTC_CORRECT);
            3'h6: wave_mode_out = 3'(ptc_pkg::PTC_SIX_SINGLE);
            3'h7: wave_mode_out = 3'(ptc_pkg::PTC_SIX_DUAL);
            default: wave_mode_out = 3'(ptc_pkg::PTC_NORMAL);
        endcase
        // top always comes from the channel c compare register in the core
        if (!any_pwm) begin
            update_at_out = 2'(ptc_pkg::PTC_UPD_IMMEDIATE);
        end else if (st_q.wave_gen[0]) begin
            update_at_out = 2'(ptc_pkg::PTC_UPD_BOTTOM);
        end else begin
            update_at_out = 2'(ptc_pkg::PTC_UPD_TOP);
        end
    end

    assign rdata_out = st_q.rdata;
    assign timer_tick_out = st_q.tick;
    assign dt_tick_out = st_q.dt_tick;
    assign dt_true_out = st_q.dt_true;
    assign dt_comp_out = st_q.dt_comp;
    assign pwm_a_out = st_q.pwm_a;
    assign pwm_b_out = st_q.pwm_b;
    assign pwm_d_out = st_q.pwm_d;
    assign mode_a_out = st_q.mode_a;
    assign wave_out_b_out = st_q.wave_b;
    assign wave_out_d_out = st_q.wave_d;
    assign compare_pin_d_out = st_q.wave_d;
    assign compare_pin_d_oe_out = st_q.mode_d != ptc_pkg::MODE_PORT;
    assign compare_pin_d_n_out = ~st_q.wave_d;
    assign compare_pin_d_n_oe_out = st_q.pwm_d && st_q.mode_d == ptc_pkg::MODE_TOGGLE;

    default clocking cb @(posedge sys_clk_in);
    endclocking
    default disable iff (reset_in);

    sequence s_force_b_clear;
        wr_ab && wdata_in[2] && wdata_in[5:4] == 2'h2 && !st_q.pwm_b;
    endsequence
    sequence s_wave_b_low;
        !wave_out_b_out;
    endsequence
    property p_force_b_action;
        s_force_b_clear |=> s_wave_b_low;
    endproperty
    a_force_b_action: assert property (p_force_b_action) else $error("force b did not clear");

    property p_force_b_ignored;
        wr_ab && wdata_in[2] && st_q.pwm_b && !match_b_in && !at_zero |=> $stable(wave_out_b_out);
    endproperty
    a_force_b_ignored: assert property (p_force_b_ignored) else $error("force b acted in pwm");

    property p_force_b_reads_zero;
        rd_in && addr_in == 8'h30 |=> !rdata_out[2];
    endproperty
    a_force_b_reads_zero: assert property (p_force_b_reads_zero) else $error("force b read one");

    property p_psr_clears;
        wr_ck && wdata_in[6] |=> st_q.presc == '0 && !timer_tick_out;
    endproperty
    a_psr_clears: assert property (p_psr_clears) else $error("prescaler not reset");

    property p_psr_reads_zero;
        rd_in && addr_in == 8'h2F |=> !rdata_out[6];
    endproperty
    a_psr_reads_zero: assert property (p_psr_reads_zero) else $error("prescaler reset read one");

    property p_invert;
        ##1 dt_true_out == ($past(dt_true_in) ^ $past(st_q.invert))
            && dt_comp_out == ($past(dt_comp_in) ^ $past(st_q.invert));
    endproperty
    a_invert: assert property (p_invert) else $error("inversion wrong");

    property p_stopped;
        st_q.clk_sel == 4'h0 && !wr_ck |=> !timer_tick_out;
    endproperty
    a_stopped: assert property (p_stopped) else $error("tick while stopped");

    property p_undivided_sync;
        st_q.clk_sel == 4'h1 && !async_mode_in && !wr_ck |=> timer_tick_out;
    endproperty
    a_undivided_sync: assert property (p_undivided_sync) else $error("no tick undivided");

    property p_shadow_a;
        rd_in && addr_in == 8'h27 |=> rdata_out[7:6] == $past(st_q.mode_a);
    endproperty
    a_shadow_a: assert property (p_shadow_a) else $error("shadow a mismatch");

    property p_comp_pin_d;
        compare_pin_d_n_oe_out == (pwm_d_out && st_q.mode_d == 2'h1);
    endproperty
    a_comp_pin_d: assert property (p_comp_pin_d) else $error("complement pin connect wrong");

    property p_force_d_toggle;
        wr_d && wdata_in[1] && wdata_in[3:2] == 2'h1 && !st_q.pwm_d && !match_d_in
            |=> wave_out_d_out != $past(wave_out_d_out);
    endproperty
    a_force_d_toggle: assert property (p_force_d_toggle) else $error("force d no toggle");

    property p_fast_d_match;
        st_q.pwm_d && !st_q.wave_gen[0] && st_q.mode_d == 2'h2 && match_d_in && !wr_d |=> !wave_out_d_out;
    endproperty
    a_fast_d_match: assert property (p_fast_d_match) else $error("fast pwm d not cleared");
endmodule

// >>> tb/ptc_timer_ctrl_tb.sv
// self-checking bench for the pwm timer control block: registers, prescalers, waveforms
// assumes the design carries its own assertions; the bench drives every port itself
`timescale 1ns/100ps
module ptc_timer_ctrl_tb;
    logic sys_clk_in = 1'b0;
    logic reset_in = 1'b1;
    logic [7:0] addr_in = 8'h00;
    logic [7:0] wdata_in = 8'h00;
    logic wr_in = 1'b0;
    logic rd_in = 1'b0;
    logic async_mode_in = 1'b0;
    logic fast_clk_tick_in = 1'b0;
    logic [9:0] counter_value_in = 10'h155;
    logic counting_down_in = 1'b0;
    logic match_b_in = 1'b0;
    logic match_d_in = 1'b0;
    logic dt_true_in = 1'b0;
    logic dt_comp_in = 1'b0;
    logic [7:0] rdata_out;
    logic timer_tick_out, dt_tick_out, dt_true_out, dt_comp_out, pwm_a_out, pwm_b_out, pwm_d_out;
    logic [1:0] mode_a_out;
    logic [1:0] update_at_out;
    logic [2:0] wave_mode_out;
    logic wave_out_b_out, wave_out_d_out, compare_pin_d_out, compare_pin_d_oe_out;
    logic compare_pin_d_n_out, compare_pin_d_n_oe_out;
    int errors = 0;
    int n_checks = 0;
    int cycles = 0;
    int t, d, sum;
    logic [1:0] modes [3] = '{2'h2, 2'h3, 2'h1};
    logic exp_w [3] = '{1'b0, 1'b1, 1'b0};

    ptc_timer_ctrl #(.CNT_W(10)) ptc_timer_ctrl_inst (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
        .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
        .async_mode_in(async_mode_in), .fast_clk_tick_in(fast_clk_tick_in),
        .counter_value_in(counter_value_in), .counting_down_in(counting_down_in),
        .match_b_in(match_b_in), .match_d_in(match_d_in), .dt_true_in(dt_true_in), .dt_comp_in(dt_comp_in),
        .timer_tick_out(timer_tick_out), .dt_tick_out(dt_tick_out), .dt_true_out(dt_true_out),
        .dt_comp_out(dt_comp_out), .pwm_a_out(pwm_a_out), .pwm_b_out(pwm_b_out), .pwm_d_out(pwm_d_out),
        .mode_a_out(mode_a_out), .wave_mode_out(wave_mode_out), .update_at_out(update_at_out),
        .wave_out_b_out(wave_out_b_out), .wave_out_d_out(wave_out_d_out),
        .compare_pin_d_out(compare_pin_d_out), .compare_pin_d_oe_out(compare_pin_d_oe_out),
        .compare_pin_d_n_out(compare_pin_d_n_out), .compare_pin_d_n_oe_out(compare_pin_d_n_oe_out));

    initial begin
        forever #12.5 sys_clk_in = ~sys_clk_in;
    end

    // fast peripheral clock modelled as a tick every other system cycle
    always @(posedge sys_clk_in) begin
        fast_clk_tick_in <= async_mode_in & ~fast_clk_tick_in;
    end

    always @(posedge sys_clk_in) begin
        cycles++;
        if (cycles == 20000) begin
            errors++;
            $display("mismatch at %0t: run hung", $time);
            finish_test();
        end
    end

    task automatic finish_test();
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task automatic chk_reg(input logic [7:0] got, input logic [7:0] exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %h exp %h", $time, msg, got, exp);
        end
    endtask

    task automatic chk_bit(input logic got, input logic exp, input string msg);
        n_checks++;
        if (got !== exp) begin
            errors++;
            $display("mismatch at %0t: %s got %b exp %b", $time, msg, got, exp);
        end
    endtask

    task automatic chk_cnt(input int got, input int exp, input string msg);
        n_checks++;
        if (got != exp) begin
            errors++;
            $display("mismatch at %0t: %s got %0d exp %0d", $time, msg, got, exp);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge sys_clk_in);
        addr_in <= a;
        wdata_in <= v;
        wr_in <= 1'b1;
        @(posedge sys_clk_in);
        wr_in <= 1'b0;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] exp, input string msg);
        @(posedge sys_clk_in);
        addr_in <= a;
        rd_in <= 1'b1;
        @(posedge sys_clk_in);
        rd_in <= 1'b0;
        #1;
        chk_reg(rdata_out, exp, msg);
    endtask

    task automatic settle();
        repeat (3) @(posedge sys_clk_in);
        #1;
    endtask

    // skip a few cycles first so a prescaler restart never lands in the window
    task automatic count(input int n, output int tk, output int dk);
        tk = 0;
        dk = 0;
        repeat (4) @(posedge sys_clk_in);
        repeat (n) begin
            @(posedge sys_clk_in);
            #1;
            tk += int'(timer_tick_out);
            dk += int'(dt_tick_out);
        end
    endtask

    // kind 0: counter at zero, 1: match b, 2: match d
    task automatic evt(input int kind, input logic down);
        @(posedge sys_clk_in);
        counting_down_in <= down;
        if (kind == 0)
            counter_value_in <= 10'h000;
        else if (kind == 1)
            match_b_in <= 1'b1;
        else
            match_d_in <= 1'b1;
        @(posedge sys_clk_in);
        counter_value_in <= 10'h155;
        match_b_in <= 1'b0;
        match_d_in <= 1'b0;
        settle();
    endtask

    task automatic test_regs();
        rdchk(8'h27, 8'h00, "ctrl d reset");
        rdchk(8'h2F, 8'h00, "clk ctrl reset");
        rdchk(8'h30, 8'h00, "ctrl ab reset");
        rdchk(8'h10, 8'h00, "unmapped read");
        chk_bit(compare_pin_d_n_out, 1'b1, "comp pin idle");
        wr(8'h10, 8'hFF);
        wr(8'h2F, 8'hF0);
        rdchk(8'h2F, 8'hB0, "clk ctrl readback");
        wr(8'h30, 8'hC7);
        rdchk(8'h30, 8'hC3, "ctrl ab readback");
        chk_bit(pwm_a_out, 1'b1, "pwm a");
        chk_bit(pwm_b_out, 1'b1, "pwm b");
        rdchk(8'h27, 8'hC0, "shadow of ab");
        chk_reg({6'h00, mode_a_out}, 8'h03, "mode a");
        wr(8'h27, 8'h61);
        rdchk(8'h30, 8'h63, "shadow write to ab");
        chk_bit(pwm_d_out, 1'b1, "pwm d");
        wr(8'h27, 8'h02);
        rdchk(8'h27, 8'h00, "force d reads zero");
        wr(8'h30, 8'h00);
        $display("test regs done");
    endtask

    task automatic test_presc();
        @(posedge sys_clk_in);
        dt_true_in <= 1'b1;
        wr(8'h2F, 8'h00);
        settle();
        chk_bit(dt_true_out, 1'b1, "dt true plain");
        wr(8'h2F, 8'h80);
        settle();
        chk_bit(dt_true_out, 1'b0, "dt true inverted");
        chk_bit(dt_comp_out, 1'b1, "dt comp inverted");
        count(64, t, d);
        chk_cnt(t, 0, "stopped timer");
        for (int s = 1; s <= 6; s++) begin
            wr(8'h2F, 8'h40 | 8'(s));
            count(128, t, d);
            chk_cnt(t, 128 >> (s - 1), "sync divide");
        end
        for (int k = 0; k < 4; k++) begin
            wr(8'h2F, 8'h01 | 8'(k << 4));
            count(128, t, d);
            chk_cnt(d, 128 >> k, "dead-time divide");
        end
        async_mode_in <= 1'b1;
        wr(8'h2F, 8'h02);
        count(128, t, d);
        chk_cnt(t, 32, "async divide");
        async_mode_in <= 1'b0;
        sum = 0;
        // restarting every ten cycles keeps a divide by 16 from ever firing
        repeat (8) begin
            wr(8'h2F, 8'h45);
            count(4, t, d);
            sum += t;
        end
        chk_cnt(sum, 0, "prescaler held in reset");
        wr(8'h2F, 8'h00);
        $display("test presc done");
    endtask

    task automatic test_chan_b();
        wr(8'h26, 8'h00);
        wr(8'h30, 8'h34);
        settle();
        chk_bit(wave_out_b_out, 1'b1, "force b set");
        wr(8'h30, 8'h24);
        settle();
        chk_bit(wave_out_b_out, 1'b0, "force b new mode");
        wr(8'h30, 8'h31);
        wr(8'h30, 8'h35);
        settle();
        chk_bit(wave_out_b_out, 1'b0, "force b in pwm");
        wr(8'h30, 8'h10);
        evt(1, 1'b0);
        chk_bit(wave_out_b_out, 1'b1, "match b toggle");
        wr(8'h30, 8'h14);
        settle();
        chk_bit(wave_out_b_out, 1'b0, "force b toggle");
        $display("test chan b done");
    endtask

    task automatic test_chan_d();
        for (int i = 0; i < 3; i++) begin
            wr(8'h27, {4'h0, modes[i], 2'b10});
            settle();
            chk_bit(wave_out_d_out, exp_w[i], "force d");
            chk_bit(compare_pin_d_out, exp_w[i], "pin d");
            chk_bit(compare_pin_d_oe_out, 1'b1, "pin d override");
            chk_bit(compare_pin_d_n_oe_out, 1'b0, "comp d off");
        end
        evt(2, 1'b0);
        chk_bit(wave_out_d_out, 1'b1, "match d toggle");
        wr(8'h27, 8'h02);
        settle();
        chk_bit(compare_pin_d_oe_out, 1'b0, "port mode");
        chk_bit(wave_out_d_out, 1'b1, "force in port mode");
        wr(8'h27, 8'h05);
        settle();
        chk_reg({5'h00, wave_mode_out}, 8'h01, "fast mode");
        chk_reg({6'h00, update_at_out}, 8'h01, "update at top");
        chk_bit(compare_pin_d_n_oe_out, 1'b1, "comp d on");
        evt(2, 1'b0);
        chk_bit(wave_out_d_out, 1'b0, "fast clear on match");
        evt(0, 1'b0);
        chk_bit(wave_out_d_out, 1'b1, "fast set at zero");
        chk_bit(compare_pin_d_n_out, 1'b0, "comp d level");
        wr(8'h27, 8'h0F);
        settle();
        chk_bit(wave_out_d_out, 1'b1, "force ignored in pwm");
        evt(0, 1'b0);
        chk_bit(wave_out_d_out, 1'b0, "inverted clear at zero");
        evt(2, 1'b0);
        chk_bit(wave_out_d_out, 1'b1, "inverted set on match");
        chk_bit(compare_pin_d_n_oe_out, 1'b0, "comp d mode 11");
        wr(8'h26, 8'h01);
        wr(8'h27, 8'h09);
        settle();
        chk_reg({5'h00, wave_mode_out}, 8'h02, "correct mode");
        chk_reg({6'h00, update_at_out}, 8'h02, "update at bottom");
        evt(2, 1'b0);
        chk_bit(wave_out_d_out, 1'b0, "up match clears");
        evt(2, 1'b1);
        chk_bit(wave_out_d_out, 1'b1, "down match sets");
        wr(8'h27, 8'h0D);
        evt(2, 1'b1);
        chk_bit(wave_out_d_out, 1'b0, "reverse down clears");
        evt(2, 1'b0);
        chk_bit(wave_out_d_out, 1'b1, "reverse up sets");
        wr(8'h26, 8'h02);
        settle();
        chk_reg({5'h00, wave_mode_out}, 8'h03, "six single");
        wr(8'h26, 8'h03);
        settle();
        chk_reg({5'h00, wave_mode_out}, 8'h04, "six dual");
        wr(8'h27, 8'h00);
        settle();
        chk_reg({5'h00, wave_mode_out}, 8'h00, "normal mode");
        chk_reg({6'h00, update_at_out}, 8'h00, "update immediate");
        $display("test chan d done");
    endtask

    initial begin
        repeat (5) @(posedge sys_clk_in);
        reset_in <= 1'b0;
        test_regs();
        test_presc();
        test_chan_b();
        test_chan_d();
        finish_test();
    end
endmodule
